// ### tscs_edge_det.sv
// Edge detector for the sampled oscillator levels
`timescale 1ns/1ps
module tscs_edge_det #(
  parameter int unsigned N = 2
) (
  // Clock and reset
  input  wire logic         i_ref_clk,
  input  wire logic         i_rstn,
  // Sampled levels
  input  wire logic [N-1:0] i_level,
  // One-cycle edge pulses
  output logic      [N-1:0] o_rise,
  output logic      [N-1:0] o_fall
);

  logic [N-1:0] prev_r;

  // Previous level for each input
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      prev_r <= '0;
    end else begin
      prev_r <= i_level;
    end
  end

  // Compare against the stored level, one bit per input
  for (genvar g = 0; g < N; g++) begin : g_edge
    assign o_rise[g] = i_level[g] & ~prev_r[g];
    assign o_fall[g] = ~i_level[g] & prev_r[g];
  end

endmodule // tscs_edge_det

// ### tscs_ext_osc_model.sv
// Behavioural external crystal oscillator at the block's far side
`timescale 1ns/1ps
module tscs_ext_osc_model #(
  parameter int unsigned HALF = 3
) (
  // Sampling clock and run control
  input  wire logic i_clk,
  input  wire logic i_run,
  // Oscillator level
  output logic      o_osc
);
  int unsigned cnt_r = 0;
  // Level stands still while stopped, as a crystal does in sleep
  initial o_osc = 1'b0;
  always @(posedge i_clk) begin
    if (i_run) begin
      cnt_r <= (cnt_r == HALF - 1) ? 0 : cnt_r + 1;
      if (cnt_r == HALF - 1) o_osc <= ~o_osc;
    end
  end
endmodule // tscs_ext_osc_model

// ### tscs_pkg.sv
// Package of constants and types for the two-speed clock start-up block
package tscs_pkg;

  // Oscillator select field encodings
  localparam logic [2:0] OSEL_HIGH_POWER_CLOCK_INPUT = 3'h7;
  localparam logic [2:0] OSEL_MID_POWER_CLOCK_INPUT  = 3'h6;
  localparam logic [2:0] OSEL_LOW_POWER_CLOCK_INPUT  = 3'h5;
  localparam logic [2:0] OSEL_INTERNAL_OSCILLATOR    = 3'h4;
  localparam logic [2:0] OSEL_RESISTOR_CAPACITOR_OSC = 3'h3;
  localparam logic [2:0] OSEL_HIGH_SPEED_CRYSTAL     = 3'h2;
  localparam logic [2:0] OSEL_STANDARD_CRYSTAL_MODE  = 3'h1;
  localparam logic [2:0] OSEL_LOW_POWER_CRYSTAL      = 3'h0;

  // System clock select value that allows two-speed start-up
  localparam logic [1:0] SYS_CLK_SEL_CONFIG = 2'h0;

  // Stabilization counter length in external cycles
  localparam int unsigned STAB_COUNT  = 1024;
  localparam int unsigned STAB_CNT_W  = 11;

  // Register byte addresses
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_IRQ_ST = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MK = 4'hC;

  // Control register fields
  localparam int unsigned CTRL_SCS_LSB  = 0;
  localparam int unsigned CTRL_IRCF_LSB = 4;
  localparam logic [1:0]  CTRL_SCS_RST  = 2'h0;
  localparam logic [3:0]  CTRL_IRCF_RST = 4'h7;

  // Status register fields
  localparam int unsigned ST_READY_BIT = 0;
  localparam int unsigned ST_ON_EXT    = 1;
  localparam int unsigned ST_TWO_SPEED = 2;
  localparam int unsigned ST_WARMING   = 3;

  // Interrupt bits: ready set, start-up aborted
  localparam int unsigned IRQ_W        = 2;
  localparam int unsigned IRQ_READY    = 0;
  localparam int unsigned IRQ_ABORT    = 1;
  localparam logic [1:0]  IRQ_MASK_RST = 2'h0;

  // Which clock drives the system
  typedef enum logic [1:0] {
    TSCS_SRC_INTERNAL,
    TSCS_SRC_HELD_LOW,
    TSCS_SRC_EXTERNAL
  } tscs_src_t;

  // Static configuration word fields
  typedef struct packed {
    logic       dual_speed_enable;
    logic [2:0] oscillator_select_field;
    logic       power_up_delay_timer_en;
  } tscs_cfg_t;

  // Edge events sampled from the oscillators
  typedef struct packed {
    logic ext_rise;
    logic ext_fall;
    logic int_fall;
  } tscs_edges_t;

endpackage

// ### tscs_properties.sv
// Checker properties for the two-speed start-up block
`timescale 1ns/1ps
module tscs_chk import tscs_pkg::*; #(
  parameter int unsigned STAB_CYCLES = 1024
) (
  // Watched ports
  input wire logic                i_ref_clk,
  input wire logic                i_rstn,
  input wire tscs_pkg::tscs_cfg_t i_cfg,
  input wire logic                i_sleep_enter,
  input wire logic                i_wake,
  input wire logic                i_ext_osc,
  input wire logic [3:0]          i_avs_address,
  input wire logic                i_avs_read,
  input wire logic                i_avs_write,
  input wire tscs_pkg::tscs_src_t o_clk_src,
  input wire logic                o_sys_clk_hold_low,
  input wire logic [3:0]          o_int_freq_select,
  input wire logic                o_avs_waitrequest
);
  logic [15:0] rise_cnt_r;
  logic        ext_q_r;
  // Raw external rises; counts early, so it bounds the design from above
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rise_cnt_r <= 16'h0;
      ext_q_r    <= 1'b0;
    end else begin
      ext_q_r <= i_ext_osc;
      if (i_wake || i_sleep_enter) rise_cnt_r <= 16'h0;
      else if (i_ext_osc && !ext_q_r) rise_cnt_r <= rise_cnt_r + 16'h1;
    end
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  property p_rd_ans; i_avs_read && o_avs_waitrequest |=> !o_avs_waitrequest; endproperty
  property p_wr_ans; i_avs_write |-> !o_avs_waitrequest; endproperty
  property p_held_xtal;
    o_clk_src == TSCS_SRC_HELD_LOW |-> i_cfg.oscillator_select_field <= OSEL_HIGH_SPEED_CRYSTAL;
  endproperty
  property p_held_flag; o_clk_src == TSCS_SRC_HELD_LOW |-> o_sys_clk_hold_low; endproperty
  property p_ext_fall;
    ($past(o_clk_src) == TSCS_SRC_HELD_LOW && o_clk_src == TSCS_SRC_EXTERNAL)
      |-> (!$past(i_ext_osc) || !$past(i_ext_osc, 2) || !$past(i_ext_osc, 3));
  endproperty
  property p_no_skip;
    ($past(o_clk_src) == TSCS_SRC_INTERNAL && o_clk_src == TSCS_SRC_EXTERNAL)
      |-> i_cfg.oscillator_select_field >= OSEL_RESISTOR_CAPACITOR_OSC;
  endproperty
  property p_count;
    ($past(o_clk_src) != TSCS_SRC_HELD_LOW && o_clk_src == TSCS_SRC_HELD_LOW)
      |-> rise_cnt_r >= STAB_CYCLES - 1;
  endproperty
  property p_abort;
    i_sleep_enter && o_clk_src == TSCS_SRC_INTERNAL |=> o_clk_src != TSCS_SRC_HELD_LOW [*3];
  endproperty
  property p_wake_int;
    i_wake && i_cfg.oscillator_select_field <= OSEL_HIGH_SPEED_CRYSTAL
      |=> o_clk_src == TSCS_SRC_INTERNAL;
  endproperty
  property p_ircf;
    $changed(o_int_freq_select) |-> $past(i_avs_write) && $past(i_avs_address) == ADDR_CTRL;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  a_wr_ans: assert property (p_wr_ans) else $error("write stalled");
  a_held_xtal: assert property (p_held_xtal) else $error("held low off crystal");
  a_held_flag: assert property (p_held_flag) else $error("hold flag low");
  a_ext_fall: assert property (p_ext_fall) else $error("switch without fall");
  a_no_skip: assert property (p_no_skip) else $error("crystal skipped hold");
  a_count: assert property (p_count) else $error("count too short");
  a_abort: assert property (p_abort) else $error("sleep did not abort");
  a_wake_int: assert property (p_wake_int) else $error("wake not internal");
  a_ircf: assert property (p_ircf) else $error("freq select moved");
  c_switch: cover property ($past(o_clk_src) == TSCS_SRC_HELD_LOW && o_clk_src == TSCS_SRC_EXTERNAL);
  c_abort: cover property (i_sleep_enter && o_clk_src == TSCS_SRC_INTERNAL);
  c_read: cover property (i_avs_read && !o_avs_waitrequest);
endmodule // tscs_chk

bind tscs_two_speed_startup tscs_chk #(.STAB_CYCLES(STAB_CYCLES)) i_chk (.i_ref_clk, .i_rstn,
  .i_cfg, .i_sleep_enter, .i_wake, .i_ext_osc, .i_avs_address, .i_avs_read, .i_avs_write,
  .o_clk_src, .o_sys_clk_hold_low, .o_int_freq_select, .o_avs_waitrequest);

// ### tscs_two_speed_startup.sv
// Two-speed clock start-up controller with Avalon-MM register slave
//
// How it works
// - Three-bit select field picks the clock mode.
// - Crystal modes count 1024 external cycles first.
// - Non-crystal modes skip two-speed start-up unless the secondary switch is set.
// - Count reached before sleep sets ready, switches.
// - Sleep during start-up aborts, ready stays clear.
// - Enable bit and select 00 only set the status bit; any crystal mode counts.
// - Entered after power-on or wake; waits timer.
// - Run immediately on internal oscillator, chosen frequency.
// - After timeout wait internal falling edge, set ready.
// - Hold system clock low until crystal falls.
// - Crystal or secondary switch waits 1024 cycles.
// - Internal oscillator sources wait the warm-up delay.
// - Software reads the on-external status bit to learn source.
`timescale 1ns/1ps
module tscs_two_speed_startup #(
  parameter int unsigned STAB_CYCLES = tscs_pkg::STAB_COUNT,
  parameter int unsigned WARM_CYCLES = 16
) (
  // Clock and reset
  input  wire logic                i_ref_clk,
  input  wire logic                i_rstn,
  // Configuration word
  input  wire tscs_pkg::tscs_cfg_t i_cfg,
  // Power and sleep events
  input  wire logic                i_power_up_delay_timer_expired,
  input  wire logic                i_sleep_enter,
  input  wire logic                i_wake,
  input  wire logic                i_secondary_switch,
  // Sampled oscillator levels
  input  wire logic                i_ext_osc,
  input  wire logic                i_int_osc,
  // System clock source select
  output tscs_pkg::tscs_src_t      o_clk_src,
  output logic                     o_sys_clk_hold_low,
  output logic [3:0]               o_int_freq_select,
  // Avalon-MM slave
  input  wire logic [3:0]          i_avs_address,
  input  wire logic                i_avs_read,
  input  wire logic                i_avs_write,
  input  wire logic [31:0]         i_avs_writedata,
  output logic [31:0]              o_avs_readdata,
  output logic                     o_avs_waitrequest,
  // Interrupt
  output logic                     o_irq
);
  import tscs_pkg::*;

  typedef enum {
    ST_IDLE,
    ST_WAIT_POWER_UP_DELAY_TIMER,
    ST_COUNT,
    ST_WAIT_INT_FALL,
    ST_WAIT_EXT_FALL,
    ST_RUN_EXT,
    ST_WARM,
    ST_RUN_INT
  } tscs_state_t;

  // Crystal test, used for mode decisions and the status readback
  function automatic logic is_crystal(input logic [2:0] sel);
    return (sel == OSEL_LOW_POWER_CRYSTAL) ||
           (sel == OSEL_STANDARD_CRYSTAL_MODE) ||
           (sel == OSEL_HIGH_SPEED_CRYSTAL);
  endfunction

  // Internal source test: internal oscillator mode needs warm-up
  function automatic logic is_internal(input logic [2:0] sel);
    return sel == OSEL_INTERNAL_OSCILLATOR;
  endfunction

  tscs_state_t            state_r;
  tscs_state_t            state_nxt;
  logic [STAB_CNT_W-1:0]  cnt_r;
  logic [15:0]            warm_r;
  logic                   ready_r;
  logic                   por_pending_r;
  logic [1:0]             scs_r;
  logic [3:0]             ircf_r;
  logic [IRQ_W-1:0]       irq_st_r;
  logic [IRQ_W-1:0]       irq_mk_r;
  logic [31:0]            rdata_r;
  logic                   rd_ack_r;
  logic [1:0]             rise;
  logic [1:0]             fall;
  tscs_edges_t            edges;
  logic                   two_speed_ok;
  logic                   entry;
  logic                   cnt_done;
  logic                   warm_done;
  logic                   set_ready_ev;
  logic                   abort_ev;
  logic                   wr_ctrl;
  logic                   wr_irq_st;
  logic                   wr_irq_mk;

  // Edge pulses of both oscillators
  tscs_edge_det #(
    .N (2)
  ) u_edges (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .i_level   ({i_int_osc, i_ext_osc}),
    .o_rise    (rise),
    .o_fall    (fall)
  );

  assign edges = '{ext_rise: rise[0], ext_fall: fall[0], int_fall: fall[1]};

  // Start-up qualification from configuration and control
  assign two_speed_ok = i_cfg.dual_speed_enable && (scs_r == SYS_CLK_SEL_CONFIG) &&
                        is_crystal(i_cfg.oscillator_select_field);
  assign entry        = i_wake || (por_pending_r &&
                        (i_power_up_delay_timer_expired || !i_cfg.power_up_delay_timer_en));
  assign cnt_done     = (cnt_r == STAB_CNT_W'(STAB_CYCLES - 1)) && edges.ext_rise;
  assign warm_done    = (warm_r == 16'(WARM_CYCLES - 1));
  assign set_ready_ev = (state_r == ST_WAIT_INT_FALL) && edges.int_fall &&
                        !i_sleep_enter;
  assign abort_ev     = i_sleep_enter && ((state_r == ST_COUNT) ||
                        (state_r == ST_WAIT_INT_FALL));

  // Power-on entry is remembered until the power-up timer lets it go
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      por_pending_r <= 1'b1;
    end else if (entry) begin
      por_pending_r <= 1'b0;
    end
  end

  // Next state of the start-up sequence
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE, ST_WAIT_POWER_UP_DELAY_TIMER, ST_RUN_INT, ST_RUN_EXT: begin
        if (por_pending_r && !entry) begin
          state_nxt = ST_WAIT_POWER_UP_DELAY_TIMER;
        end else if (entry && i_secondary_switch) begin
          state_nxt = ST_COUNT;
        end else if (entry && two_speed_ok) begin
          state_nxt = ST_COUNT;
        end else if (entry && is_internal(i_cfg.oscillator_select_field)) begin
          state_nxt = ST_WARM;
        end else if (entry) begin
          state_nxt = is_crystal(i_cfg.oscillator_select_field) ? ST_COUNT
                                                                 : ST_RUN_EXT;
        end else if (i_sleep_enter) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_COUNT: begin
        if (i_sleep_enter) begin
          state_nxt = ST_IDLE;
        end else if (cnt_done) begin
          state_nxt = ST_WAIT_INT_FALL;
        end
      end
      ST_WAIT_INT_FALL: begin
        if (i_sleep_enter) begin
          state_nxt = ST_IDLE;
        end else if (edges.int_fall) begin
          state_nxt = ST_WAIT_EXT_FALL;
        end
      end
      ST_WAIT_EXT_FALL: begin
        if (edges.ext_fall) begin
          state_nxt = ST_RUN_EXT;
        end
      end
      ST_WARM: begin
        if (i_sleep_enter) begin
          state_nxt = ST_IDLE;
        end else if (warm_done) begin
          state_nxt = ST_RUN_INT;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Stabilization counter counts external rising edges only while counting
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_r <= '0;
    end else if (state_r != ST_COUNT || i_sleep_enter) begin
      cnt_r <= '0;
    end else if (edges.ext_rise && !cnt_done) begin
      cnt_r <= cnt_r + STAB_CNT_W'(1);
    end
  end

  // Warm-up delay counter for the internal sources
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      warm_r <= '0;
    end else if (state_r != ST_WARM) begin
      warm_r <= '0;
    end else if (!warm_done) begin
      warm_r <= warm_r + 16'h0001;
    end
  end

  // Ready flag: cleared on entry, set after internal falling edge
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ready_r <= 1'b0;
    end else if (set_ready_ev) begin
      ready_r <= 1'b1;
    end else if (entry || i_sleep_enter) begin
      ready_r <= 1'b0;
    end
  end

  // Clock source outputs, registered through the state
  always_comb begin
    case (state_r)
      ST_WAIT_EXT_FALL: o_clk_src = TSCS_SRC_HELD_LOW;
      ST_RUN_EXT:       o_clk_src = TSCS_SRC_EXTERNAL;
      default:          o_clk_src = TSCS_SRC_INTERNAL;
    endcase
  end
  assign o_sys_clk_hold_low = (state_r == ST_WAIT_EXT_FALL) || (state_r == ST_WARM);
  assign o_int_freq_select  = ircf_r;

  // Register write decode
  assign wr_ctrl   = i_avs_write && (i_avs_address == ADDR_CTRL);
  assign wr_irq_st = i_avs_write && (i_avs_address == ADDR_IRQ_ST);
  assign wr_irq_mk = i_avs_write && (i_avs_address == ADDR_IRQ_MK);

  // Control register: clock select and internal frequency
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      scs_r  <= CTRL_SCS_RST;
      ircf_r <= CTRL_IRCF_RST;
    end else if (wr_ctrl) begin
      scs_r  <= i_avs_writedata[CTRL_SCS_LSB +: 2];
      ircf_r <= i_avs_writedata[CTRL_IRCF_LSB +: 4];
    end
  end

  // Sticky events; a new event wins over a same-cycle clear
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_st_r <= '0;
    end else begin
      irq_st_r <= (irq_st_r & ~(wr_irq_st ? i_avs_writedata[IRQ_W-1:0] : '0))
                  | {abort_ev, set_ready_ev};
    end
  end

  // Interrupt mask
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_mk_r <= IRQ_MASK_RST;
    end else if (wr_irq_mk) begin
      irq_mk_r <= i_avs_writedata[IRQ_W-1:0];
    end
  end

  assign o_irq = |(irq_st_r & irq_mk_r);

  // Reads answer one cycle later; writes complete at once
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rd_ack_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
    end else begin
      rd_ack_r <= i_avs_read && !rd_ack_r;
      if (i_avs_read && !rd_ack_r) begin
        case (i_avs_address)
          ADDR_CTRL:   rdata_r <= {24'h000000, ircf_r, 2'h0, scs_r};
          ADDR_STATUS: rdata_r <= {28'h0000000, o_sys_clk_hold_low, two_speed_ok,
                                   state_r == ST_RUN_EXT, ready_r};
          ADDR_IRQ_ST: rdata_r <= {30'h00000000, irq_st_r};
          ADDR_IRQ_MK: rdata_r <= {30'h00000000, irq_mk_r};
          default:     rdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign o_avs_readdata    = rdata_r;
  assign o_avs_waitrequest = i_avs_read && !rd_ack_r;

endmodule // tscs_two_speed_startup

// ### two_speed_clock_startup_tb_top.sv
// Testbench for the two-speed start-up block
`timescale 1ns/1ps
module two_speed_clock_startup_tb_top;
  import tscs_pkg::*;
  logic i_ref_clk = 0, i_rstn = 0, power_up_delay_timer = 0, slp = 0, wk = 0, io = 0, xo, run = 1;
  logic rd = 0, wr = 0, hold, irq, saw_held = 0, saw_warm = 0;
  logic [3:0] addr = 0, ircf;
  logic [31:0] wdata = 0, rdata, q;
  logic wreq;
  tscs_cfg_t cfg = '{1'b1, OSEL_LOW_POWER_CRYSTAL, 1'b1};
  tscs_src_t src;
  int errors = 0, cmp_count = 0;
  tscs_two_speed_startup #(.STAB_CYCLES(8), .WARM_CYCLES(4)) i_dut (.i_ref_clk, .i_rstn,
    .i_cfg(cfg), .i_power_up_delay_timer_expired(power_up_delay_timer), .i_sleep_enter(slp), .i_wake(wk),
    .i_secondary_switch(1'b0), .i_ext_osc(xo), .i_int_osc(io), .o_clk_src(src),
    .o_sys_clk_hold_low(hold), .o_int_freq_select(ircf), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .o_irq(irq));
  tscs_ext_osc_model i_xo (.i_clk(i_ref_clk), .i_run(run), .o_osc(xo));
  // Clocks: internal oscillator is much slower than the reference
  initial forever #2.5 i_ref_clk = ~i_ref_clk;
  always begin
    repeat (4) @(posedge i_ref_clk);
    io <= ~io;
  end
  always @(posedge i_ref_clk) begin
    if (src === TSCS_SRC_HELD_LOW && hold === 1'b1) saw_held <= 1'b1;
    if (src === TSCS_SRC_INTERNAL && hold === 1'b1) saw_warm <= 1'b1;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s exp %0h got %0h", nm, e, g);
    end
  endtask
  // Hold the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_ref_clk);
    addr <= a;
    wdata <= d;
    rd <= !w;
    wr <= w;
    // Waitrequest and read data are taken at the same rising edge
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (n == 50) errors++;
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    // Let the write settle before outputs are looked at
    @(negedge i_ref_clk);
  endtask
  task automatic pulse(input logic [1:0] sw, input int gap);
    @(posedge i_ref_clk);
    {slp, wk} <= sw;
    @(posedge i_ref_clk);
    {slp, wk} <= 2'b00;
    repeat (gap) @(posedge i_ref_clk);
  endtask
  task automatic end_of_test;
    if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    end_of_test;
  end
  initial begin
    repeat (8) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    repeat (40) @(posedge i_ref_clk);
    chk("src_power_up_delay_timer", TSCS_SRC_INTERNAL, src);
    bus(0, ADDR_CTRL, 0);
    chk("ctrl_rst", 32'h70, q);
    power_up_delay_timer <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
    bus(0, ADDR_STATUS, 0);
    chk("st_count", 32'h4, q);
    chk("src_count", TSCS_SRC_INTERNAL, src);
    repeat (150) @(posedge i_ref_clk);
    chk("src_ext", TSCS_SRC_EXTERNAL, src);
    chk("saw_held", 1, saw_held);
    bus(0, ADDR_STATUS, 0);
    chk("st_ready", 32'h7, q);
    bus(1, ADDR_STATUS, 0);
    bus(0, ADDR_STATUS, 0);
    chk("st_ro", 32'h7, q);
    bus(0, ADDR_IRQ_ST, 0);
    chk("irq_ready", 32'h1, q);
    chk("irq_masked", 0, irq);
    bus(1, ADDR_IRQ_MK, 32'h3);
    chk("irq_on", 1, irq);
    bus(1, ADDR_IRQ_ST, 32'h1);
    chk("irq_clr", 0, irq);
    bus(0, 4'h2, 0);
    chk("unmapped", 0, q);
    run <= 1'b0;
    pulse(2'b10, 4);
    run <= 1'b1;
    pulse(2'b01, 10);
    pulse(2'b10, 2);
    bus(0, ADDR_STATUS, 0);
    chk("st_abort", 0, q[0]);
    bus(0, ADDR_IRQ_ST, 0);
    chk("irq_abort", 32'h2, q);
    bus(1, ADDR_IRQ_ST, 32'h2);
    bus(1, ADDR_CTRL, 32'h51);
    chk("ircf", 4'h5, ircf);
    pulse(2'b01, 4);
    bus(0, ADDR_STATUS, 0);
    chk("st_scs", 0, q[2]);
    pulse(2'b10, 2);
    bus(1, ADDR_CTRL, 32'h70);
    cfg.dual_speed_enable <= 1'b0;
    pulse(2'b01, 4);
    bus(0, ADDR_STATUS, 0);
    chk("st_dual", 0, q[2]);
    cfg.dual_speed_enable <= 1'b1;
    // Every non-crystal mode takes its source without the count
    for (int m = 3; m < 8; m++) begin
      pulse(2'b10, 2);
      cfg.oscillator_select_field <= m[2:0];
      pulse(2'b01, 30);
      chk("mode_src", (m == 4) ? TSCS_SRC_INTERNAL : TSCS_SRC_EXTERNAL, src);
      chk("mode_hold", 0, hold);
    end
    chk("saw_warm", 1, saw_warm);
    end_of_test;
  end
endmodule // two_speed_clock_startup_tb_top
